// ===== core/retimer_channel_monitor_regs.sv
// channel monitor, threshold and sticky flag registers
`timescale 1ns/1ps
`default_nettype none
`include "chan_mon_params.svh"
module retimer_channel_monitor_regs (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire chan_mon_pkg::reg_req_t req_in,
  input wire chan_mon_pkg::chan_obs_t obs_in,
  input wire chan_mon_pkg::flag_en_t en_in,
  output chan_mon_pkg::reg_rsp_t rsp_out,
  output chan_mon_pkg::limits_t limits_out
);
  import chan_mon_pkg::*;

  // ==========================================================
  // state
  logic [7:0] eye_thr_r, eye_thr_nxt;
  logic [7:0] reg77_r, reg77_nxt;
  logic sd_prev_r, sd_prev_nxt;
  logic lock_prev_r, lock_prev_nxt;
  logic lock_flag_r, lock_flag_nxt;
  logic sd_flag_r, sd_flag_nxt;
  logic eye_flag_r, eye_flag_nxt;
  reg_rsp_t rsp_r, rsp_nxt;
  logic wr_hit, rd_status, lock_ev, sd_ev, eye_ev;
  logic [5:0] veo_lim, heo_lim;

  // ==========================================================
  // events
  always_comb begin
    veo_lim = {eye_thr_r[7:4], {`EYE_STEP_SHIFT{1'b0}}};
    heo_lim = {eye_thr_r[3:0], {`EYE_STEP_SHIFT{1'b0}}};
    lock_ev = en_in.lock_gain_flag_enable & obs_in.recovery_locked_live & ~lock_prev_r;
    sd_ev = en_in.input_change_flag_enable & (obs_in.input_present_live ^ sd_prev_r);
    eye_ev = en_in.eye_flag_enable & ((obs_in.veo_meas < veo_lim) | (obs_in.heo_meas < heo_lim));
    wr_hit = req_in.valid & req_in.write;
    rd_status = req_in.valid & ~req_in.write & (req_in.addr == `ADDR_STATUS);
  end

  // ==========================================================
  // threshold registers
  always_comb begin
    eye_thr_nxt = eye_thr_r;
    reg77_nxt = reg77_r;
    if (wr_hit && req_in.addr == `ADDR_EYE_THR) begin
      eye_thr_nxt = req_in.wdata;
    end
    if (wr_hit && req_in.addr == `ADDR_SBT_THR) begin
      reg77_nxt = req_in.wdata;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      eye_thr_r <= `RST_EYE_THR;
      reg77_r <= {`RST_CTRL77_HI, `RST_SBT_THR};
      limits_out <= '0;
    end else begin
      eye_thr_r <= eye_thr_nxt;
      reg77_r <= reg77_nxt;
      limits_out <= {eye_thr_nxt, reg77_nxt[4:0]};
    end
  end

  // ==========================================================
  // input history for edge detection
  always_comb begin
    sd_prev_nxt = obs_in.input_present_live;
    lock_prev_nxt = obs_in.recovery_locked_live;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sd_prev_r <= 1'h0;
      lock_prev_r <= 1'h0;
    end else begin
      sd_prev_r <= sd_prev_nxt;
      lock_prev_r <= lock_prev_nxt;
    end
  end

  // ==========================================================
  // sticky flags, set wins over read clear
  always_comb begin
    lock_flag_nxt = lock_ev | (lock_flag_r & ~rd_status);
    sd_flag_nxt = sd_ev | (sd_flag_r & ~rd_status);
    eye_flag_nxt = eye_ev | (eye_flag_r & ~rd_status);
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      lock_flag_r <= 1'h0;
      sd_flag_r <= 1'h0;
      eye_flag_r <= 1'h0;
    end else begin
      lock_flag_r <= lock_flag_nxt;
      sd_flag_r <= sd_flag_nxt;
      eye_flag_r <= eye_flag_nxt;
    end
  end

  // ==========================================================
  // read response
  always_comb begin
    rsp_nxt.valid = req_in.valid & ~req_in.write;
    rsp_nxt.rdata = 8'h00;
    if (req_in.valid && !req_in.write) begin
      case (req_in.addr)
        `ADDR_TAP5: rsp_nxt.rdata = {3'h0, obs_in.tap5_sign_view, obs_in.tap5_weight_view};
        `ADDR_EYE_THR: rsp_nxt.rdata = eye_thr_r;
        `ADDR_SBT_THR: rsp_nxt.rdata = reg77_r;
        `ADDR_STATUS: rsp_nxt.rdata = {2'h0, obs_in.input_present_live, obs_in.recovery_locked_live,
                                       lock_flag_r, sd_flag_r, 1'h0, eye_flag_r};
        default: rsp_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  always_comb begin
    rsp_out = rsp_r;
  end

  // ==========================================================
  // checks
  a_lock_rise_sets: assert property (@(posedge clock_in) disable iff (rst_in)
    lock_ev |=> lock_flag_r) else $error("lock flag not set on rise");
  a_lock_gated: assert property (@(posedge clock_in) disable iff (rst_in)
    (!lock_flag_r && !en_in.lock_gain_flag_enable) |=> !lock_flag_r) else $error("lock flag set while disabled");
  a_sd_change_sets: assert property (@(posedge clock_in) disable iff (rst_in)
    (en_in.input_change_flag_enable && $changed(obs_in.input_present_live)) |=> sd_flag_r)
    else $error("detect flag missed change");
  a_sd_gated: assert property (@(posedge clock_in) disable iff (rst_in)
    (!sd_flag_r && !en_in.input_change_flag_enable) |=> !sd_flag_r) else $error("detect flag set while disabled");
  a_eye_gated: assert property (@(posedge clock_in) disable iff (rst_in)
    (!eye_flag_r && !en_in.eye_flag_enable) |=> !eye_flag_r) else $error("eye flag set while disabled");
  a_flag_sticky: assert property (@(posedge clock_in) disable iff (rst_in)
    (lock_flag_r && !rd_status) |=> lock_flag_r) else $error("lock flag dropped without read");
  a_read_clears: assert property (@(posedge clock_in) disable iff (rst_in)
    (rd_status && !eye_ev) |=> !eye_flag_r) else $error("eye flag not cleared by read");
  a_status_read: assert property (@(posedge clock_in) disable iff (rst_in)
    rd_status |=> (rsp_out.valid && rsp_out.rdata[7:6] == 2'h0 && rsp_out.rdata[1] == 1'h0))
    else $error("status reserved bits not zero");
  a_tap5_read: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_in.valid && !req_in.write && req_in.addr == `ADDR_TAP5) |=>
    rsp_out.rdata == {3'h0, $past(obs_in.tap5_sign_view), $past(obs_in.tap5_weight_view)})
    else $error("tap5 read wrong");

  // ==========================================================
  // further checks
  a_lock_fall_quiet: assert property (@(posedge clock_in) disable iff (rst_in)
    (!lock_flag_r && $fell(obs_in.recovery_locked_live)) |=> !lock_flag_r)
    else $error("lock flag set on loss of lock");
  a_lock_steady_quiet: assert property (@(posedge clock_in) disable iff (rst_in)
    (!lock_flag_r && $stable(obs_in.recovery_locked_live)) |=> !lock_flag_r)
    else $error("lock flag set without rise");
  a_sd_still_quiet: assert property (@(posedge clock_in) disable iff (rst_in)
    (!sd_flag_r && !$changed(obs_in.input_present_live)) |=> !sd_flag_r)
    else $error("detect flag set without change");
  a_sd_sticky: assert property (@(posedge clock_in) disable iff (rst_in)
    (sd_flag_r && !rd_status) |=> sd_flag_r)
    else $error("detect flag dropped without read");
  a_eye_sticky: assert property (@(posedge clock_in) disable iff (rst_in)
    (eye_flag_r && !rd_status) |=> eye_flag_r)
    else $error("eye flag dropped without read");
  a_lock_read_clears: assert property (@(posedge clock_in) disable iff (rst_in)
    (rd_status && !lock_ev) |=> !lock_flag_r)
    else $error("lock flag not cleared by read");
  a_sd_read_clears: assert property (@(posedge clock_in) disable iff (rst_in)
    (rd_status && !sd_ev) |=> !sd_flag_r)
    else $error("detect flag not cleared by read");
  a_eye_vert_sets: assert property (@(posedge clock_in) disable iff (rst_in)
    (en_in.eye_flag_enable && obs_in.veo_meas < {eye_thr_r[7:4], {`EYE_STEP_SHIFT{1'b0}}}) |=> eye_flag_r)
    else $error("eye flag missed vertical drop");
  a_eye_horiz_sets: assert property (@(posedge clock_in) disable iff (rst_in)
    (en_in.eye_flag_enable && obs_in.heo_meas < {eye_thr_r[3:0], {`EYE_STEP_SHIFT{1'b0}}}) |=> eye_flag_r)
    else $error("eye flag missed horizontal drop");
  a_eye_open_quiet: assert property (@(posedge clock_in) disable iff (rst_in)
    (!eye_flag_r && obs_in.veo_meas >= veo_lim && obs_in.heo_meas >= heo_lim) |=> !eye_flag_r)
    else $error("eye flag set with open eye");
  a_vert_limit_write: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_hit && req_in.addr == `ADDR_EYE_THR) |=> limits_out.locked_vertical_limit == $past(req_in.wdata[7:4]))
    else $error("vertical limit not written");
  a_horiz_limit_write: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_hit && req_in.addr == `ADDR_EYE_THR) |=> limits_out.locked_horizontal_limit == $past(req_in.wdata[3:0]))
    else $error("horizontal limit not written");
  a_sbt_limit_write: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_hit && req_in.addr == `ADDR_SBT_THR) |=> limits_out.locked_sbt_limit == $past(req_in.wdata[4:0]))
    else $error("sbt limit not written");
  a_eye_thr_readback: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_in.valid && !req_in.write && req_in.addr == `ADDR_EYE_THR) |=>
    rsp_out.rdata == {limits_out.locked_vertical_limit, limits_out.locked_horizontal_limit})
    else $error("eye limit read wrong");
  a_sbt_readback: assert property (@(posedge clock_in) disable iff (rst_in)
    (req_in.valid && !req_in.write && req_in.addr == `ADDR_SBT_THR) |=>
    rsp_out.rdata[4:0] == limits_out.locked_sbt_limit) else $error("sbt limit read wrong");
  a_live_status_read: assert property (@(posedge clock_in) disable iff (rst_in)
    rd_status |=> (rsp_out.rdata[`BIT_SD_LIVE] == $past(obs_in.input_present_live) &&
    rsp_out.rdata[`BIT_LOCK_LIVE] == $past(obs_in.recovery_locked_live))) else $error("live status read wrong");
endmodule : retimer_channel_monitor_regs
`default_nettype wire

// ===== core/chan_mon_params.svh
// constants for the channel monitor register group
`ifndef CHAN_MON_PARAMS_SVH
`define CHAN_MON_PARAMS_SVH
`define ADDR_TAP5 8'h75
`define ADDR_EYE_THR 8'h76
`define ADDR_SBT_THR 8'h77
`define ADDR_STATUS 8'h78
`define RST_EYE_THR 8'h22
`define RST_SBT_THR 5'h1A
`define RST_CTRL77_HI 3'h0
`define BIT_SIGN 4
`define BIT_SD_LIVE 5
`define BIT_LOCK_LIVE 4
`define BIT_LOCK_FLAG 3
`define BIT_SD_FLAG 2
`define BIT_EYE_FLAG 0
`define EYE_STEP_SHIFT 2
`endif

// ===== core/chan_mon_pkg.sv
// types for the channel monitor register group
`default_nettype none
package chan_mon_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } reg_rsp_t;
  typedef struct packed {
    logic tap5_sign_view;
    logic [3:0] tap5_weight_view;
    logic input_present_live;
    logic recovery_locked_live;
    logic [5:0] veo_meas;
    logic [5:0] heo_meas;
  } chan_obs_t;
  typedef struct packed {
    logic lock_gain_flag_enable;
    logic input_change_flag_enable;
    logic eye_flag_enable;
  } flag_en_t;
  typedef struct packed {
    logic [3:0] locked_vertical_limit;
    logic [3:0] locked_horizontal_limit;
    logic [4:0] locked_sbt_limit;
  } limits_t;
endpackage : chan_mon_pkg
`default_nettype wire

// ===== dv/retimer_channel_monitor_regs_tb.sv
// self-checking bench for the channel monitor register group
`timescale 1ns/1ps
`default_nettype none
module retimer_channel_monitor_regs_tb;
  import chan_mon_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  reg_req_t req = '0;
  chan_obs_t obs = '0;
  flag_en_t en = '0;
  reg_rsp_t rsp;
  limits_t lim;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hAF27;
  int thr76, thr77, fl, pv_sd, pv_lk, exp_v, exp_d;
  // ====================
  // clock, design, timeout
  always #2.5 clock_in = ~clock_in;
  retimer_channel_monitor_regs DUT (.clock_in(clock_in), .rst_in(rst_in), .req_in(req), .obs_in(obs),
    .en_in(en), .rsp_out(rsp), .limits_out(lim));
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      give_verdict();
    end
  end
  // ====================
  // helpers and model
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic do_reset();
    rst_in = 1'b1;
    req = '0;
    obs = '0;
    en = '0;
    repeat (20) @(negedge clock_in);
    rst_in = 1'b0;
    thr76 = 8'h22;
    thr77 = 8'h1A;
    fl = 0;
    pv_sd = 0;
    pv_lk = 0;
    exp_v = 0;
  endtask : do_reset
  task automatic step(input int t);
    @(negedge clock_in);
    check({7'h00, rsp.valid}, exp_v[7:0]);
    if (exp_v != 0) check(rsp.rdata, exp_d[7:0]);
    check({lim.locked_vertical_limit, lim.locked_horizontal_limit}, thr76[7:0]);
    check({3'h0, lim.locked_sbt_limit}, thr77[7:0] & 8'h1F);
    seed = lfsr(seed);
    req.valid = seed[0];
    req.write = seed[1] & seed[2];
    req.addr = 8'h74 + {5'h00, seed[5:3]};
    req.wdata = seed[13:6];
    if (req.addr == 8'h77) req.wdata[7] = 1'b0;
    repeat (7) seed = lfsr(seed);
    obs = seed[18:0];
    en = (t != 0) ? seed[21:19] : 3'h0;
    exp_v = req.valid & ~req.write;
    case (req.addr)
      8'h75: exp_d = {3'h0, obs.tap5_sign_view, obs.tap5_weight_view};
      8'h76: exp_d = thr76;
      8'h77: exp_d = thr77;
      8'h78: exp_d = {2'h0, obs.input_present_live, obs.recovery_locked_live, fl[2:1], 1'b0, fl[0]};
      default: exp_d = 0;
    endcase
    if (exp_v != 0 && req.addr == 8'h78) fl = 0;
    fl |= {en.lock_gain_flag_enable & obs.recovery_locked_live & (pv_lk == 0),
      en.input_change_flag_enable & (obs.input_present_live != pv_sd),
      en.eye_flag_enable & (obs.veo_meas < 4 * thr76[7:4] || obs.heo_meas < 4 * thr76[3:0])};
    if (req.valid && req.write && req.addr == 8'h76) thr76 = req.wdata;
    if (req.valid && req.write && req.addr == 8'h77) thr77 = req.wdata;
    pv_lk = obs.recovery_locked_live;
    pv_sd = obs.input_present_live;
  endtask : step
  initial begin
    for (int t = 0; t < 2; t++) begin
      do_reset();
      repeat (1500) step(t);
      $display("test %0d done", t);
    end
    give_verdict();
  end
endmodule : retimer_channel_monitor_regs_tb
`default_nettype wire
